// ==== counter_host.sv ====
// Controller end: configures, pre-loads, runs and snapshots the counter.
// Assumes the device end shares SYS_CLK and NRST.
`timescale 1ns/1ns
`include "ectr_regs.svh"

module counter_host (
    input  wire logic       SYS_CLK,
    input  wire logic       NRST,
    counter_if.host         BUS,
    input  wire logic       CFG_GO,
    input  wire logic [15:0] CFG_UPPER,
    input  wire logic [2:0] CFG_LOW,
    input  wire logic [4:0] CFG_DELAY,
    input  wire logic       CFG_SCALE,
    input  wire logic       SNAP_GO,
    output logic            BUSY,
    output ectr_pkg::result_t RESULT,
    output logic            RESULT_VALID
);
    import ectr_pkg::*;

    // =================================================================
    // Sequencer
    host_state_t state_q, state_d;
    logic        cen_q, cen_d;
    logic        run_q, run_d;
    logic        wr_q, wr_d;
    logic        load_q, load_d;
    upper_t      upper_q, upper_d;
    low_t        pre_q, pre_d;
    delay_t      delay_q, delay_d;
    logic        scale_q, scale_d;
    logic        freeze_q, freeze_d;
    result_t     result_q, result_d;
    logic        valid_q, valid_d;
    delay_t      delay_safe;

    // A delay that would push the tick rate above its ceiling is raised.
    always_comb begin
        delay_safe = CFG_DELAY;
        if (!CFG_SCALE && ({4'h0, CFG_DELAY} + `RATIO_BASE < 9'(`CTU_MIN_RATIO))) begin
            delay_safe = 5'(`CTU_MIN_RATIO - 4);
        end
    end

    always_comb begin
        state_d  = state_q;
        cen_d    = cen_q;
        run_d    = run_q;
        wr_d     = 1'b0;
        load_d   = 1'b0;
        upper_d  = upper_q;
        pre_d    = pre_q;
        delay_d  = delay_q;
        scale_d  = scale_q;
        freeze_d = freeze_q;
        result_d = result_q;
        valid_d  = 1'b0;
        case (state_q)
            H_IDLE, H_RUN: begin
                if (CFG_GO) begin
                    cen_d   = 1'b0;
                    run_d   = 1'b0;
                    upper_d = CFG_UPPER;
                    pre_d   = CFG_LOW;
                    delay_d = delay_safe;
                    scale_d = CFG_SCALE;
                    state_d = H_STOP;
                end else if (SNAP_GO && state_q == H_RUN) begin
                    cen_d   = 1'b0;
                    state_d = H_FREEZE;
                end
            end
            H_STOP: begin
                wr_d    = 1'b1;
                state_d = H_WRITE;
            end
            H_WRITE: begin
                load_d  = 1'b1;
                state_d = H_LOAD;
            end
            H_LOAD: begin
                state_d = H_START;
            end
            H_START: begin
                run_d   = 1'b1;
                cen_d   = 1'b1;
                state_d = H_RUN;
            end
            H_FREEZE: begin
                freeze_d = 1'b1;
                state_d  = H_WAIT;
            end
            H_WAIT: begin
                if (BUS.freeze_ack) begin
                    state_d = H_READ;
                end
            end
            H_READ: begin
                result_d = {BUS.snap_value, BUS.low_bits};
                valid_d  = 1'b1;
                freeze_d = 1'b0;
                state_d  = H_RELEASE;
            end
            H_RELEASE: begin
                if (!BUS.freeze_ack) begin
                    cen_d   = 1'b1;
                    state_d = H_RUN;
                end
            end
            default: begin
                state_d = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            state_q  <= H_IDLE;
            cen_q    <= 1'b0;
            run_q    <= 1'b0;
            wr_q     <= 1'b0;
            load_q   <= 1'b0;
            upper_q  <= `UPPER_RESET;
            pre_q    <= `LOW_RESET;
            delay_q  <= `DELAY_RESET;
            scale_q  <= 1'b0;
            freeze_q <= 1'b0;
            result_q <= `RESULT_RESET;
            valid_q  <= 1'b0;
        end else begin
            state_q  <= state_d;
            cen_q    <= cen_d;
            run_q    <= run_d;
            wr_q     <= wr_d;
            load_q   <= load_d;
            upper_q  <= upper_d;
            pre_q    <= pre_d;
            delay_q  <= delay_d;
            scale_q  <= scale_d;
            freeze_q <= freeze_d;
            result_q <= result_d;
            valid_q  <= valid_d;
        end
    end

    // =================================================================
    // Outputs
    assign BUS.count_enable   = cen_q;
    assign BUS.low_count_load = load_q;
    assign BUS.preload_bits   = pre_q;
    assign BUS.upper_wr       = wr_q;
    assign BUS.upper_wdata    = upper_q;
    assign BUS.cmd_select     = run_q;
    assign BUS.global_start   = run_q;
    assign BUS.scale_bit      = scale_q;
    assign BUS.delay_field    = delay_q;
    assign BUS.freeze_req     = freeze_q;
    assign BUSY               = (state_q != H_IDLE) && (state_q != H_RUN);
    assign RESULT             = result_q;
    assign RESULT_VALID       = valid_q;

endmodule

// ==== ectr_regs.svh ====
// Constants shared by both ends of the extended event counter.
// Assumes the includer has no other macros of the same names.
`ifndef ECTR_REGS_SVH
`define ECTR_REGS_SVH

// =====================================================================
// Widths
`define LOW_W          3
`define UPPER_W        16
`define DELAY_W        5
`define RATIO_W        9

// =====================================================================
// Pre-scaler and terminal counts
`define RATIO_BASE     9'h004
`define SCALE_SHIFT    3
`define LOW_TERMINAL   3'h7
`define UPPER_TERMINAL 16'hffff

// =====================================================================
// Reset values
`define LOW_RESET      3'h0
`define UPPER_RESET    16'h0000
`define RATIO_RESET    9'h000
`define DELAY_RESET    5'h1f
`define RESULT_RESET   19'h00000

// =====================================================================
// Timing
`define CLK_MHZ        50
`define CTU_MAX_MHZ    7
`define CTU_MIN_RATIO  ((`CLK_MHZ + `CTU_MAX_MHZ - 1) / `CTU_MAX_MHZ)

`endif

// ==== ectr_pkg.sv ====
// Types shared by both ends of the extended event counter.
// Assumes ectr_regs.svh is on the include path.
`include "ectr_regs.svh"

package ectr_pkg;
    typedef logic [`UPPER_W-1:0]          upper_t;
    typedef logic [`LOW_W-1:0]            low_t;
    typedef logic [`DELAY_W-1:0]          delay_t;
    typedef logic [`UPPER_W+`LOW_W-1:0]   result_t;
    typedef enum logic [3:0] {
        H_IDLE,
        H_STOP,
        H_WRITE,
        H_LOAD,
        H_START,
        H_RUN,
        H_FREEZE,
        H_WAIT,
        H_READ,
        H_RELEASE
    } host_state_t;
endpackage

// ==== counter_if.sv ====
// Signals between the counter device and the configuring controller.
// Assumes both ends share SYS_CLK and NRST, given to each module.
`timescale 1ns/1ns

interface counter_if;
    import ectr_pkg::*;
    logic   count_enable;
    logic   low_count_load;
    low_t   preload_bits;
    logic   upper_wr;
    upper_t upper_wdata;
    logic   cmd_select;
    logic   global_start;
    logic   scale_bit;
    delay_t delay_field;
    logic   freeze_req;
    logic   freeze_ack;
    upper_t snap_value;
    low_t   low_bits;

    modport dev (
        input  count_enable,
        input  low_count_load,
        input  preload_bits,
        input  upper_wr,
        input  upper_wdata,
        input  cmd_select,
        input  global_start,
        input  scale_bit,
        input  delay_field,
        input  freeze_req,
        output freeze_ack,
        output snap_value,
        output low_bits
    );

    modport host (
        output count_enable,
        output low_count_load,
        output preload_bits,
        output upper_wr,
        output upper_wdata,
        output cmd_select,
        output global_start,
        output scale_bit,
        output delay_field,
        output freeze_req,
        input  freeze_ack,
        input  snap_value,
        input  low_bits
    );
endinterface

// ==== extended_event_counter.sv ====
// Device end: 3-bit fast low counter feeding a pre-scaled 16-bit event counter.
// Assumes the controller end drives the interface synchronously to SYS_CLK.
`timescale 1ns/1ns
`include "ectr_regs.svh"

module extended_event_counter (
    input  wire logic  SYS_CLK,
    input  wire logic  NRST,
    counter_if.dev     BUS,
    output logic       TERM_COUNT_PIN,
    output logic       COLLECTOR_IRQ
);
    import ectr_pkg::*;

    // =================================================================
    // Pre-scaler
    logic [`RATIO_W-1:0] base_ratio;
    logic [`RATIO_W-1:0] ratio;
    logic [`RATIO_W-1:0] pre_q;
    logic [`RATIO_W-1:0] pre_d;
    logic                ctu_tick;

    always_comb begin
        base_ratio = {4'h0, BUS.delay_field} + `RATIO_BASE;
        ratio      = BUS.scale_bit ? (base_ratio << `SCALE_SHIFT) : base_ratio;
        ctu_tick   = (pre_q >= ratio - 9'h001);
        pre_d      = ctu_tick ? `RATIO_RESET : pre_q + 9'h001;
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            pre_q <= `RATIO_RESET;
        end else begin
            pre_q <= pre_d;
        end
    end

    // =================================================================
    // Low-order counter
    low_t low_q;
    low_t low_d;

    always_comb begin
        if (BUS.low_count_load) begin
            low_d = BUS.preload_bits;
        end else if (BUS.count_enable) begin
            low_d = low_q + 3'h1;
        end else begin
            low_d = low_q;
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            low_q <= `LOW_RESET;
        end else begin
            low_q <= low_d;
        end
    end

    // =================================================================
    // Event generation and capture
    // The terminal decode is taken from a flip-flop so that it carries
    // no decoding spikes into the edge detector.
    logic tick_event_q;
    logic tick_event_d;
    logic event_prev_q;
    logic event_edge;
    logic pending_q;
    logic pending_d;
    logic run;
    logic step;

    always_comb begin
        tick_event_d = (low_d == `LOW_TERMINAL);
        event_edge   = tick_event_q & ~event_prev_q;
        run          = BUS.cmd_select & BUS.global_start;
        step         = run & ctu_tick & (pending_q | event_edge);
        if (!run) begin
            pending_d = 1'b0;
        end else if (ctu_tick) begin
            pending_d = 1'b0;
        end else begin
            pending_d = pending_q | event_edge;
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            tick_event_q <= 1'b0;
            event_prev_q <= 1'b0;
            pending_q    <= 1'b0;
        end else begin
            tick_event_q <= tick_event_d;
            event_prev_q <= tick_event_q;
            pending_q    <= pending_d;
        end
    end

    // =================================================================
    // Upper counter and terminal count
    // A write from the controller takes priority over a count step in
    // the same cycle, so a pre-load is never lost.
    upper_t upper_q;
    upper_t upper_d;
    logic   term_q;
    logic   term_d;

    always_comb begin
        upper_d = upper_q;
        term_d  = 1'b0;
        if (BUS.upper_wr) begin
            upper_d = BUS.upper_wdata;
        end else if (step) begin
            upper_d = upper_q + 16'h0001;
            term_d  = (upper_q == `UPPER_TERMINAL);
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            upper_q <= `UPPER_RESET;
            term_q  <= 1'b0;
        end else begin
            upper_q <= upper_d;
            term_q  <= term_d;
        end
    end

    // =================================================================
    // Freeze and snapshot
    // The snapshot is taken in the cycle the request is first seen and
    // the acknowledge rises on that same edge, while counting goes on.
    upper_t snap_q;
    upper_t snap_d;
    logic   ack_q;
    logic   ack_d;

    always_comb begin
        snap_d = snap_q;
        ack_d  = ack_q;
        if (!BUS.freeze_req) begin
            ack_d = 1'b0;
        end else if (!ack_q) begin
            snap_d = upper_q;
            ack_d  = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            snap_q <= `UPPER_RESET;
            ack_q  <= 1'b0;
        end else begin
            snap_q <= snap_d;
            ack_q  <= ack_d;
        end
    end

    // =================================================================
    // Outputs
    assign BUS.freeze_ack  = ack_q;
    assign BUS.snap_value  = snap_q;
    assign BUS.low_bits    = low_q;
    assign TERM_COUNT_PIN  = term_q;
    assign COLLECTOR_IRQ   = term_q;

endmodule

// ==== ectr_assertions.sv ====
// Checker for the wires between the counter device and its controller.
// Assumes the bench connects the interface signals, clock and reset by name.
`timescale 1ns/1ns

module ectr_assertions (
    input wire logic             SYS_CLK,
    input wire logic             NRST,
    input wire logic             count_enable,
    input wire logic             low_count_load,
    input wire ectr_pkg::low_t   preload_bits,
    input wire logic             upper_wr,
    input wire logic             global_start,
    input wire logic             freeze_req,
    input wire logic             freeze_ack,
    input wire ectr_pkg::upper_t snap_value,
    input wire ectr_pkg::low_t   low_bits,
    input wire logic             TERM_COUNT_PIN,
    input wire logic             COLLECTOR_IRQ
);
    import ectr_pkg::*;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    // ==================================================================
    // Low counter
    a_load_wins:
        assert property (low_count_load |=> low_bits == $past(preload_bits))
        else $error("low counter missed its pre-load");
    a_low_step:
        assert property (count_enable && !low_count_load
                         |=> low_bits == low_t'($past(low_bits) + 3'h1))
        else $error("low counter did not step by one");
    a_low_hold:
        assert property (!count_enable && !low_count_load |=> $stable(low_bits))
        else $error("low counter moved while disabled");

    // ==================================================================
    // Freeze handshake and start order
    a_ack_rises:
        assert property (freeze_req && !freeze_ack |=> freeze_ack)
        else $error("freeze not acknowledged in one cycle");
    a_ack_clears:
        assert property (!freeze_req && freeze_ack |=> !freeze_ack)
        else $error("acknowledge stayed after request dropped");
    a_ack_needs_req:
        assert property (!freeze_req && !freeze_ack |=> !freeze_ack)
        else $error("acknowledge without request");
    a_snap_quiet:
        assert property (!freeze_req |=> $stable(snap_value))
        else $error("image changed without freeze request");
    a_req_held:
        assert property (freeze_req && !freeze_ack |=> freeze_req)
        else $error("freeze request dropped before acknowledge");
    a_stop_first:
        assert property ($rose(freeze_req) |-> !count_enable)
        else $error("freeze requested while low counter runs");
    a_write_first:
        assert property ($rose(global_start) |-> $past(upper_wr, 3))
        else $error("counter started without upper write");

    // ==================================================================
    // Terminal count
    a_term_pulse:
        assert property (TERM_COUNT_PIN |=> !TERM_COUNT_PIN)
        else $error("terminal pulse longer than one cycle");
    a_irq_match:
        assert property (TERM_COUNT_PIN == COLLECTOR_IRQ)
        else $error("interrupt differs from terminal pin");
endmodule

// ==== tb_top.sv ====
// Testbench joining the counter device and its controller end to end.
// Assumes the package, interface, design modules and checker compile first.
`timescale 1ns/1ns

module tb_top;
    import ectr_pkg::*;
    localparam int CYC_LIMIT = 20000;
    logic        sys_clk;
    logic        nrst;
    logic        cfg_go;
    logic [15:0] cfg_upper;
    logic [2:0]  cfg_low;
    logic [4:0]  cfg_delay;
    logic        cfg_scale;
    logic        snap_go;
    logic        busy;
    result_t     result;
    logic        result_valid;
    logic        term_pin;
    logic        irq;
    int          err_total;
    int          cmp_count;
    int          cyc_n = 0;
    counter_if   bus ();

    extended_event_counter i_extended_event_counter (.SYS_CLK(sys_clk), .NRST(nrst),
        .BUS(bus), .TERM_COUNT_PIN(term_pin), .COLLECTOR_IRQ(irq));
    counter_host i_counter_host (.SYS_CLK(sys_clk), .NRST(nrst), .BUS(bus),
        .CFG_GO(cfg_go), .CFG_UPPER(cfg_upper), .CFG_LOW(cfg_low), .CFG_DELAY(cfg_delay),
        .CFG_SCALE(cfg_scale), .SNAP_GO(snap_go), .BUSY(busy), .RESULT(result),
        .RESULT_VALID(result_valid));
    ectr_assertions u_chk (.SYS_CLK(sys_clk), .NRST(nrst), .count_enable(bus.count_enable),
        .low_count_load(bus.low_count_load), .preload_bits(bus.preload_bits),
        .upper_wr(bus.upper_wr), .global_start(bus.global_start),
        .freeze_req(bus.freeze_req), .freeze_ack(bus.freeze_ack),
        .snap_value(bus.snap_value), .low_bits(bus.low_bits),
        .TERM_COUNT_PIN(term_pin), .COLLECTOR_IRQ(irq));

    // ==================================================================
    // Clock, cycle count and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc_n <= cyc_n + 1;
    end

    // ==================================================================
    // Shared tasks
    task automatic check(input bit ok, input string msg);
        cmp_count++;
        if (!ok) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        check(busy === 1'b0, "sequence never finished");
    endtask

    task automatic configure(input logic [15:0] u, input logic [2:0] l,
                             input logic [4:0] d, input logic s);
        @(negedge sys_clk);
        cfg_upper = u;
        cfg_low = l;
        cfg_delay = d;
        cfg_scale = s;
        cfg_go = 1'b1;
        @(negedge sys_clk);
        cfg_go = 1'b0;
        check(busy === 1'b1, "configure not taken");
        wait_idle();
        check(bus.low_bits === l, "low pre-load not seen");
    endtask

    task automatic snap(output result_t r);
        int n;
        @(negedge sys_clk);
        snap_go = 1'b1;
        @(negedge sys_clk);
        snap_go = 1'b0;
        n = 0;
        while (result_valid !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        check(result_valid === 1'b1, "no snapshot result");
        r = result;
        check(r[2:0] === bus.low_bits, "low part of result wrong");
        wait_idle();
    endtask

    task automatic stop_test();
        $display("compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==================================================================
    // Scenarios
    task automatic test_reset();
        bit seen;
        check(bus.low_bits === 3'h0, "low counter not cleared");
        check(bus.snap_value === 16'h0000, "image not cleared");
        check(bus.freeze_ack === 1'b0, "acknowledge set in reset");
        check(bus.delay_field === 5'h1f, "delay field reset value");
        seen = 1'b0;
        @(negedge sys_clk);
        snap_go = 1'b1;
        @(negedge sys_clk);
        snap_go = 1'b0;
        repeat (10) begin
            @(negedge sys_clk);
            if (busy !== 1'b0 || result_valid !== 1'b0) seen = 1'b1;
        end
        check(seen === 1'b0, "snapshot taken while idle");
        $display("test reset done");
    endtask

    task automatic test_preload();
        result_t r;
        configure(16'h1234, 3'h5, 5'd12, 1'b0);
        snap(r);
        check(r[18:3] === 16'h1234 || r[18:3] === 16'h1235, "upper pre-load lost");
        check(r[2:0] === 3'h7, "low pre-load or step count wrong");
        $display("test preload done");
    endtask

    task automatic test_rates();
        logic [4:0] d_tab[3] = '{5'd12, 5'd0, 5'd31};
        logic       s_tab[3] = '{1'b0, 1'b1, 1'b1};
        int         r_tab[3] = '{16, 32, 280};
        result_t    a;
        result_t    b;
        upper_t     dv;
        int         t0;
        for (int i = 0; i < 3; i++) begin
            configure(16'h0100, 3'h0, d_tab[i], s_tab[i]);
            repeat (2 * r_tab[i]) @(negedge sys_clk);
            t0 = cyc_n;
            snap(a);
            while (cyc_n < t0 + 8 * r_tab[i]) @(negedge sys_clk);
            snap(b);
            dv = b[18:3] - a[18:3];
            check(dv === 16'h0008, "upper count rate wrong");
        end
        // A ratio below the tick ceiling must be raised by the controller.
        configure(16'h0000, 3'h0, 5'd1, 1'b0);
        check(bus.delay_field === 5'h04, "tick rate not clamped");
        $display("test rates done");
    endtask

    task automatic test_term();
        int n;
        configure(16'hfff8, 3'h0, 5'd12, 1'b0);
        n = 0;
        while (term_pin !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        check(n >= 100 && n <= 150, "terminal pulse mistimed");
        check(irq === 1'b1, "interrupt not raised");
        @(negedge sys_clk);
        check(term_pin === 1'b0, "terminal pulse too long");
        $display("test term done");
    endtask

    initial begin
        nrst = 1'b0;
        cfg_go = 1'b0;
        cfg_upper = 16'h0000;
        cfg_low = 3'h0;
        cfg_delay = 5'h00;
        cfg_scale = 1'b0;
        snap_go = 1'b0;
        err_total = 0;
        cmp_count = 0;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        nrst = 1'b1;
        fork
            begin
                test_reset();
                test_preload();
                test_rates();
                test_term();
            end
            begin
                wait (cyc_n >= CYC_LIMIT);
                err_total++;
                $display("[FAIL] %0t cycle limit reached", $time);
            end
        join_any
        stop_test();
    end
endmodule
